// [pirqe_consts.svh]
`ifndef PIRQE_CONSTS_SVH
`define PIRQE_CONSTS_SVH
// Register addresses
`define PIRQE_ADDR_MAIN_CTRL 8'h8b
`define PIRQE_ADDR_PERIPH_EN 8'h8c
`define PIRQE_ADDR_PERIPH_FLAGS 8'h0c
`define PIRQE_ADDR_TIMER0 8'h01
`define PIRQE_ADDR_IRQ_STATUS 8'h90
`define PIRQE_ADDR_IRQ_MASK 8'h91
// Main control bit positions
`define PIRQE_MC_GLOBAL_EN 7
`define PIRQE_MC_PERIPH_GATE 6
`define PIRQE_MC_T0_EN 5
`define PIRQE_MC_PIN_EN 4
`define PIRQE_MC_PORT_EN 3
`define PIRQE_MC_T0_FLAG 2
`define PIRQE_MC_PIN_FLAG 1
`define PIRQE_MC_PORT_FLAG 0
// Status bit positions
`define PIRQE_ST_PIN 2
`define PIRQE_ST_PORT 3
`define PIRQE_ST_PERIPH 4
// Reset values and timer0 maximum count
`define PIRQE_RST_MAIN_CTRL 8'h00
`define PIRQE_RST_PERIPH_EN 8'h00
`define PIRQE_RST_TIMER0 8'h00
`define PIRQE_TIMER0_MAX 8'hff
`endif

// [pirqe_pkg.sv]
package pirqe_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pirqe_bus_req_t;
  typedef struct packed {
    logic t1_gate_acq;
    logic converter_done;
    logic serial_rx;
    logic serial_tx;
    logic sync_serial;
    logic capcomp1;
    logic t2_period_match;
    logic t1_overflow;
  } pirqe_periph_ev_t;
endpackage

// [pirqe_top.sv]
// Overview of operation
// RULE1: Flags set on their source event regardless of any enable bit.
// RULE2: Software clears a flag before setting its enable bit.
// RULE3: Main control register is read/write, holds timer0, port change, pin enables and flags.
// RULE4: Peripheral interrupts reach core only when the peripheral gate bit is set.
// RULE5: Enable bit 7 gates the timer1 gate acquisition interrupt.
// RULE6: Enable bit 6 gates the converter completion interrupt.
// RULE7: Enable bit 5 gates the serial receive interrupt.
// RULE8: Enable bit 4 gates the serial transmit interrupt.
// RULE9: Enable bit 3 gates the synchronous serial port interrupt.
// RULE10: Enable bit 2 gates the capture/compare unit 1 interrupt.
// RULE11: Enable bit 1 gates the timer2 period match interrupt.
// RULE12: Enable bit 0 gates the timer1 overflow interrupt.
// RULE13: Timer0 overflow flag sets when the 8-bit count wraps from max to zero.
// RULE14: Timer0 overflow flag is cleared only by a software write.
// RULE15: Request equals global enable and (core pair or gated peripheral pair).
// RULE16: Peripheral enable register resets to all zero.
`include "pirqe_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pirqe_top #(
  parameter int NUM_SRC = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire pirqe_pkg::pirqe_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire pirqe_pkg::pirqe_periph_ev_t periph_ev,
  input wire logic timer0_tick,
  input wire logic ext_pin_ev,
  input wire logic portb_change_ev,
  output logic core_irq_req,
  output logic irq
);
  import pirqe_pkg::*;

  // Refuse any source count other than the width of the 8-bit peripheral event vector
  if (NUM_SRC != $bits(pirqe_periph_ev_t))
  begin : g_src_count_chk
    $error("source count must match the peripheral event vector");
  end

  logic [7:0] main_ctrl_q, main_ctrl_d;
  logic [7:0] periph_en_q, periph_en_d;
  logic [7:0] periph_flags_q, periph_flags_d;
  logic [7:0] timer0_count_q, timer0_count_d;
  logic [7:0] irq_status_q, irq_status_d;
  logic [7:0] irq_mask_q, irq_mask_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] ev_vec;
  logic [7:0] periph_pend;
  logic [2:0] core_pend;
  logic t0_wrap;
  logic wr_main, wr_pen, wr_pfl, wr_t0, wr_msk, rd_sts;
  logic req_comb;

  // Decoded strobes
  assign wr_main = bus_req.wr && bus_req.addr == `PIRQE_ADDR_MAIN_CTRL;
  assign wr_pen = bus_req.wr && bus_req.addr == `PIRQE_ADDR_PERIPH_EN;
  assign wr_pfl = bus_req.wr && bus_req.addr == `PIRQE_ADDR_PERIPH_FLAGS;
  assign wr_t0 = bus_req.wr && bus_req.addr == `PIRQE_ADDR_TIMER0;
  assign wr_msk = bus_req.wr && bus_req.addr == `PIRQE_ADDR_IRQ_MASK;
  assign rd_sts = bus_req.rd && bus_req.addr == `PIRQE_ADDR_IRQ_STATUS;

  // Event vector in enable-bit order, bit 7 down to bit 0
  assign ev_vec = periph_ev;
  // Timer0 wraps from max to zero on a tick, unless software writes it
  assign t0_wrap = timer0_tick && !wr_t0 && timer0_count_q == `PIRQE_TIMER0_MAX; // RULE13

  // Per-source gating by enable bit
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_gate
      assign periph_pend[gi] = periph_flags_q[gi] & periph_en_q[gi]; // RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11 RULE12
      // Each source event leaves its flag set one cycle later
      a_src_flag: assert property ( // RULE1
        @(posedge clk) disable iff (srst)
        ev_vec[gi] |=> periph_flags_q[gi])
        else $error("source event did not set its flag");
      // A raised flag stays until software writes the flag register
      a_src_flag_hold: assert property ( // RULE1
        @(posedge clk) disable iff (srst)
        periph_flags_q[gi] && !wr_pfl |=> periph_flags_q[gi])
        else $error("source flag dropped without a write");
      // An enabled flag behind open gates reaches the core
      a_src_pass: assert property ( // RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11 RULE12
        @(posedge clk) disable iff (srst)
        main_ctrl_q[`PIRQE_MC_GLOBAL_EN] && main_ctrl_q[`PIRQE_MC_PERIPH_GATE] &&
        periph_flags_q[gi] && periph_en_q[gi] |-> core_irq_req)
        else $error("enabled source did not request");
      // A lone flag with its enable clear stays away from the core
      a_src_block: assert property ( // RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11 RULE12
        @(posedge clk) disable iff (srst)
        periph_flags_q == (8'h01 << gi) && !periph_en_q[gi] && !(|core_pend) |-> !core_irq_req)
        else $error("disabled source requested");
    end
  endgenerate

  assign core_pend[2] = main_ctrl_q[`PIRQE_MC_T0_EN] & main_ctrl_q[`PIRQE_MC_T0_FLAG];
  assign core_pend[1] = main_ctrl_q[`PIRQE_MC_PIN_EN] & main_ctrl_q[`PIRQE_MC_PIN_FLAG];
  assign core_pend[0] = main_ctrl_q[`PIRQE_MC_PORT_EN] & main_ctrl_q[`PIRQE_MC_PORT_FLAG];

  // Combined request to the core
  assign req_comb = main_ctrl_q[`PIRQE_MC_GLOBAL_EN] &
    ((|core_pend) | (main_ctrl_q[`PIRQE_MC_PERIPH_GATE] & (|periph_pend))); // RULE15 RULE4
  assign core_irq_req = req_comb;
  assign irq = |(irq_status_q & irq_mask_q);
  assign rdata = rdata_q;

  // Next-state for registers and flags
  always_comb
  begin
    main_ctrl_d = main_ctrl_q;
    periph_en_d = periph_en_q;
    periph_flags_d = periph_flags_q;
    timer0_count_d = timer0_count_q;
    irq_status_d = irq_status_q;
    irq_mask_d = irq_mask_q;
    rdata_d = 8'h00;
    if (wr_main)
      main_ctrl_d = bus_req.wdata; // RULE3 RULE14
    if (wr_pen)
      periph_en_d = bus_req.wdata;
    if (wr_pfl)
      periph_flags_d = bus_req.wdata;
    if (wr_msk)
      irq_mask_d = bus_req.wdata;
    if (wr_t0)
      timer0_count_d = bus_req.wdata;
    else if (timer0_tick)
      timer0_count_d = 8'(timer0_count_q + 8'h01);
    // Sources set flags irrespective of enables; set wins over clear
    periph_flags_d = periph_flags_d | ev_vec; // RULE1
    main_ctrl_d[`PIRQE_MC_T0_FLAG] = main_ctrl_d[`PIRQE_MC_T0_FLAG] | t0_wrap; // RULE13 RULE1
    main_ctrl_d[`PIRQE_MC_PIN_FLAG] = main_ctrl_d[`PIRQE_MC_PIN_FLAG] | ext_pin_ev;
    main_ctrl_d[`PIRQE_MC_PORT_FLAG] = main_ctrl_d[`PIRQE_MC_PORT_FLAG] | portb_change_ev;
    // Sticky status: bit0 core request level, bits 1-3 core events, bit4 peripheral event
    if (rd_sts)
      irq_status_d = 8'h00;
    irq_status_d = irq_status_d | {3'h0, |ev_vec, portb_change_ev, ext_pin_ev, t0_wrap, req_comb};
    // Read mux
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        `PIRQE_ADDR_MAIN_CTRL: rdata_d = main_ctrl_q;
        `PIRQE_ADDR_PERIPH_EN: rdata_d = periph_en_q;
        `PIRQE_ADDR_PERIPH_FLAGS: rdata_d = periph_flags_q;
        `PIRQE_ADDR_TIMER0: rdata_d = timer0_count_q;
        `PIRQE_ADDR_IRQ_STATUS: rdata_d = irq_status_q;
        `PIRQE_ADDR_IRQ_MASK: rdata_d = irq_mask_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      main_ctrl_q <= `PIRQE_RST_MAIN_CTRL;
      periph_en_q <= `PIRQE_RST_PERIPH_EN; // RULE16
      periph_flags_q <= 8'h00;
      timer0_count_q <= `PIRQE_RST_TIMER0;
      irq_status_q <= 8'h00;
      irq_mask_q <= 8'h00;
      rdata_q <= 8'h00;
    end
    else
    begin
      main_ctrl_q <= main_ctrl_d;
      periph_en_q <= periph_en_d;
      periph_flags_q <= periph_flags_d;
      timer0_count_q <= timer0_count_d;
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
      rdata_q <= rdata_d;
    end
  end

  // Timer1 overflow event leaves its flag set one cycle later
  a_flag_sets: assert property ( // RULE1
    @(posedge clk) disable iff (srst)
    periph_ev[0] |=> periph_flags_q[0])
    else $error("flag not set by event");

  // A wrap of the timer0 count raises its overflow flag and lands on zero
  a_t0_wrap_flag: assert property ( // RULE13
    @(posedge clk) disable iff (srst)
    timer0_tick && !wr_t0 && timer0_count_q == `PIRQE_TIMER0_MAX |=>
    main_ctrl_q[`PIRQE_MC_T0_FLAG] && timer0_count_q == 8'h00)
    else $error("timer0 wrap did not set flag");

  // Only a write to the main control register may drop the timer0 flag
  a_t0_flag_hold: assert property ( // RULE14
    @(posedge clk) disable iff (srst)
    main_ctrl_q[`PIRQE_MC_T0_FLAG] && !wr_main |=> main_ctrl_q[`PIRQE_MC_T0_FLAG])
    else $error("timer0 flag cleared by hardware");

  // A quiet write to the main control register lands whole
  a_main_write: assert property ( // RULE3
    @(posedge clk) disable iff (srst)
    wr_main && !timer0_tick && !ext_pin_ev && !portb_change_ev |=> main_ctrl_q == $past(bus_req.wdata))
    else $error("main control write lost");

  // A closed peripheral gate keeps peripheral requests from the core
  a_peripheral_irq_gate_gate: assert property ( // RULE4
    @(posedge clk) disable iff (srst)
    !main_ctrl_q[`PIRQE_MC_PERIPH_GATE] && !(|core_pend) |-> !core_irq_req)
    else $error("peripheral irq passed closed gate");

  // Gate acquisition source passes with every gate open
  a_bit7_gate: assert property ( // RULE5
    @(posedge clk) disable iff (srst)
    main_ctrl_q[`PIRQE_MC_GLOBAL_EN] && main_ctrl_q[`PIRQE_MC_PERIPH_GATE] && periph_flags_q[7] && periph_en_q[7] |-> core_irq_req)
    else $error("gate acquisition irq not passed");

  // An enable alone never makes a request
  a_bit0_block: assert property ( // RULE12
    @(posedge clk) disable iff (srst)
    periph_en_q == 8'h01 && !periph_flags_q[0] && !(|core_pend) |-> !core_irq_req)
    else $error("timer1 overflow irq without flag");

  // Nothing reaches the core while the global enable is clear
  a_gie_gate: assert property ( // RULE15
    @(posedge clk) disable iff (srst)
    !main_ctrl_q[`PIRQE_MC_GLOBAL_EN] |-> !core_irq_req)
    else $error("request without global enable");

  // Reset leaves every peripheral source disabled
  a_en_reset: assert property ( // RULE16
    @(posedge clk)
    srst |=> periph_en_q == `PIRQE_RST_PERIPH_EN)
    else $error("enable register not reset");

  // Pin event raises its flag whatever the enables hold
  a_pin_flag: assert property ( // RULE1 RULE3
    @(posedge clk) disable iff (srst)
    ext_pin_ev |=> main_ctrl_q[`PIRQE_MC_PIN_FLAG])
    else $error("pin event did not set its flag");

  // Port change event raises its flag whatever the enables hold
  a_port_flag: assert property ( // RULE1 RULE3
    @(posedge clk) disable iff (srst)
    portb_change_ev |=> main_ctrl_q[`PIRQE_MC_PORT_FLAG])
    else $error("port event did not set its flag");

  // An enabled pin flag requests under the global enable
  a_core_pin_pass: assert property ( // RULE15
    @(posedge clk) disable iff (srst)
    main_ctrl_q[`PIRQE_MC_GLOBAL_EN] && main_ctrl_q[`PIRQE_MC_PIN_EN] && main_ctrl_q[`PIRQE_MC_PIN_FLAG] |-> core_irq_req)
    else $error("pin flag did not request");

  // An enabled port flag requests under the global enable
  a_core_port_pass: assert property ( // RULE15
    @(posedge clk) disable iff (srst)
    main_ctrl_q[`PIRQE_MC_GLOBAL_EN] && main_ctrl_q[`PIRQE_MC_PORT_EN] && main_ctrl_q[`PIRQE_MC_PORT_FLAG] |-> core_irq_req)
    else $error("port flag did not request");

  // Each tick without a timer0 write moves the timer0 count on by one
  a_t0_count: assert property ( // RULE13
    @(posedge clk) disable iff (srst)
    timer0_tick && !wr_t0 |=> timer0_count_q == 8'($past(timer0_count_q) + 8'h01))
    else $error("timer0 count did not advance");

  // The timer0 flag rises only on a wrap or a write
  a_t0_only_wrap: assert property ( // RULE13
    @(posedge clk) disable iff (srst)
    !t0_wrap && !wr_main && !main_ctrl_q[`PIRQE_MC_T0_FLAG] |=> !main_ctrl_q[`PIRQE_MC_T0_FLAG])
    else $error("timer0 flag rose without a wrap");

  // A read of the main control register returns it the cycle after
  a_main_read: assert property ( // RULE3
    @(posedge clk) disable iff (srst)
    bus_req.rd && bus_req.addr == `PIRQE_ADDR_MAIN_CTRL |=> rdata == $past(main_ctrl_q))
    else $error("main control read data wrong");

  // Read data stays at zero outside the cycle after a read
  a_rdata_idle: assert property (
    @(posedge clk) disable iff (srst)
    !bus_req.rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");

  // A read of the status register empties it when nothing new arrives
  a_status_clear: assert property (
    @(posedge clk) disable iff (srst)
    rd_sts && !(|ev_vec) && !t0_wrap && !ext_pin_ev && !portb_change_ev && !req_comb |=> irq_status_q == 8'h00)
    else $error("status not cleared by read");

  // Pin event leaves its sticky status bit set
  a_status_pin: assert property ( // RULE1
    @(posedge clk) disable iff (srst)
    ext_pin_ev |=> irq_status_q[`PIRQE_ST_PIN])
    else $error("pin status bit not set");

  // Port change event leaves its sticky status bit set
  a_status_port: assert property ( // RULE1
    @(posedge clk) disable iff (srst)
    portb_change_ev |=> irq_status_q[`PIRQE_ST_PORT])
    else $error("port status bit not set");

  // Any peripheral event leaves its sticky status bit set
  a_status_periph: assert property ( // RULE1
    @(posedge clk) disable iff (srst)
    (|ev_vec) |=> irq_status_q[`PIRQE_ST_PERIPH])
    else $error("peripheral status bit not set");

  // The enable register changes only when software writes it
  a_en_hold: assert property (
    @(posedge clk) disable iff (srst)
    !wr_pen |=> periph_en_q == $past(periph_en_q))
    else $error("enable register changed without a write");
endmodule
`default_nettype wire

// [pirqe_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pirqe_src_model (
  input wire logic clk,
  input wire logic [10:0] fire,
  output var pirqe_pkg::pirqe_periph_ev_t periph_ev,
  output logic timer0_tick,
  output logic ext_pin_ev,
  output logic portb_change_ev
);
  import pirqe_pkg::*;

  // Each requested source event leaves as a one-cycle pulse after the clock edge
  always_ff @(posedge clk)
  begin
    {portb_change_ev, ext_pin_ev, timer0_tick, periph_ev} <= fire;
  end
endmodule
`default_nettype wire

// [peripheral_interrupt_enable_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pirqe_consts.svh"
module peripheral_interrupt_enable_tb;
  import pirqe_pkg::*;
  localparam logic [7:0] ad_mc = `PIRQE_ADDR_MAIN_CTRL;
  localparam logic [7:0] ad_pe = `PIRQE_ADDR_PERIPH_EN;
  localparam logic [7:0] ad_pf = `PIRQE_ADDR_PERIPH_FLAGS;
  logic clk = 1'b0;
  logic srst = 1'b1;
  pirqe_bus_req_t bus_req = '0;
  logic [10:0] fire = '0;
  logic [7:0] rdata;
  logic [7:0] got;
  pirqe_periph_ev_t periph_ev;
  logic timer0_tick, ext_pin_ev, portb_change_ev, core_irq_req, irq;
  int err_total = 0;
  int samples_checked = 0;
  // 50 ns period
  always #25 clk = ~clk;
  pirqe_src_model i_src (.clk(clk), .fire(fire), .periph_ev(periph_ev), .timer0_tick(timer0_tick),
    .ext_pin_ev(ext_pin_ev), .portb_change_ev(portb_change_ev));
  pirqe_top i_dut (.clk(clk), .srst(srst), .bus_req(bus_req), .rdata(rdata), .periph_ev(periph_ev),
    .timer0_tick(timer0_tick), .ext_pin_ev(ext_pin_ev), .portb_change_ev(portb_change_ev),
    .core_irq_req(core_irq_req), .irq(irq));
  // Compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus_req.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus_req.rd <= 1'b0;
    #1 got = rdata;
  endtask
  // Ask the source model for events, return once the design has seen them
  task automatic pulse(input logic [10:0] m);
    @(posedge clk) fire <= m;
    @(posedge clk) fire <= '0;
    @(posedge clk) #1;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(ad_pe); chk("enable reset", got, `PIRQE_RST_PERIPH_EN);
    wr(ad_mc, 8'h38); rd(ad_mc); chk("main rw", got, 8'h38);
    rd(8'h55); chk("unmapped", got, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(ad_pf, 8'h00);
      wr(ad_pe, 8'h01 << i);
      wr(ad_mc, 8'h80);
      pulse(11'h001 << i); chk("gate off", core_irq_req, 1'b0);
      rd(ad_pf); chk("flag", got, 8'h01 << i);
      wr(ad_mc, 8'hc0); rd(ad_pe); chk("gated req", core_irq_req, 1'b1);
      wr(ad_pf, 8'h00); pulse(11'h001 << ((i + 1) % 8)); chk("other src", core_irq_req, 1'b0);
    end
    wr(ad_mc, 8'ha0); wr(`PIRQE_ADDR_TIMER0, 8'hfe);
    pulse(11'h100); chk("no wrap", core_irq_req, 1'b0);
    pulse(11'h100); chk("wrap req", core_irq_req, 1'b1);
    rd(`PIRQE_ADDR_TIMER0); chk("count", got, 8'h00);
    repeat (5) @(posedge clk);
    rd(ad_mc); chk("t0 flag held", got, 8'ha4);
    wr(ad_mc, 8'ha0); rd(ad_mc); chk("t0 cleared", got, 8'ha0);
    chk("req low", core_irq_req, 1'b0);
    wr(ad_mc, 8'h90); pulse(11'h200); chk("pin req", core_irq_req, 1'b1);
    rd(ad_mc); chk("pin flag", got, 8'h92);
    wr(ad_mc, 8'h88); pulse(11'h400); chk("port req", core_irq_req, 1'b1);
    rd(ad_mc); chk("port flag", got, 8'h89);
    wr(ad_mc, 8'h00); rd(`PIRQE_ADDR_IRQ_STATUS); chk("status all", got, 8'h1f);
    wr(`PIRQE_ADDR_IRQ_MASK, 8'h04); rd(`PIRQE_ADDR_IRQ_MASK); chk("mask", got, 8'h04);
    pulse(11'h200); chk("irq on", irq, 1'b1);
    rd(`PIRQE_ADDR_IRQ_STATUS); chk("status", got, 8'h04);
    chk("irq cleared", irq, 1'b0);
    wr(`PIRQE_ADDR_IRQ_MASK, 8'h00); pulse(11'h400); chk("irq masked", irq, 1'b0);
    rd(`PIRQE_ADDR_IRQ_STATUS); chk("status masked", got, 8'h08);
    // Reset again in mid-run with the enables set
    wr(ad_pe, 8'hff); rd(ad_pe); chk("enable set", got, 8'hff);
    @(posedge clk) srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(ad_pe); chk("enable reset again", got, `PIRQE_RST_PERIPH_EN);
    chk("req after reset", core_irq_req, 1'b0);
    wrap_up();
  end
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
